/* File: include/rtc_consts.svh */
// Offsets, field positions, reset values and timing counts of the reject timer
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
`define RTC_CTRL_OFS   8'h00
`define RTC_PSEL_OFS   8'h04
`define RTC_NEW_OFS    8'h08
`define RTC_STAT_OFS   8'h0c
`define RTC_PRM_BASE   8'h40
`define RTC_ST_FLAG    1
`define RTC_ST_OVF     2
`define RTC_CTRL_RST   4'h0
`define RTC_PRM_RST    16'h0000
`define RTC_REJ_RST    16'h4e20
`define RTC_CLK_NS     4
`define RTC_TICK_NS    10000
`define RTC_TICK_CYC   (`RTC_TICK_NS / `RTC_CLK_NS)
`define RTC_OKAY       2'b00
`define RTC_SLVERR     2'b10
`endif

/* File: include/rtc_pkg.sv */
// Types shared by the reject timer
package rtc_pkg;
   typedef struct packed {
      logic tacho_pol;
      logic tacho_en;
      logic photo_pol;
      logic photo_en;
   } rtc_cfg_s;
   typedef struct packed {
      logic window;
      logic ovf;
      logic flag;
      logic relay;
   } rtc_stat_s;
   typedef enum logic [1:0] {PRM_DELAY, PRM_REJECT, PRM_PDELAY, PRM_ALARM} rtc_prm_e;
endpackage : rtc_pkg

/* File: rtl/rtc_top.sv */
// Per-product reject timing controller with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"
// Behaviour
// - Each detection edge makes a trigger that loads the active product's delay.
// - Without photocell, delay expiry fires the reject relay at once.
// - Relay stays on for the programmed reject duration, then releases.
// - A trigger gets its own delay slot while one of DEPTH is free; with all busy it is dropped and sets overflow.
// - A delay value of zero fires without added delay.
// - With photocell, delay expiry opens an alarm window of the alarm duration.
// - With photocell, rejects happen only while the alarm window is open.
// - Each photocell beam break starts its own photocell delay countdown while one of DEPTH slots is free; with all busy it is dropped and sets overflow.
// - Photocell delay expiry fires the relay only if the window is open.
// - Variable speed makes trigger and photocell delays count tacho pulses.
// - Each reject sets a sticky reject indication flag.
// - Each product keeps its own timer set; the selected set governs.
// - A new product copies the active product's timer set.
// - Photocell and tacho inputs each have enable and polarity bits.
// - Variable speed counts all values but reject duration in tacho pulses.
// - Without photocell, photocell delay and alarm values have no effect.
module rtc_top #(
   parameter int NPROD = 4,
   parameter int DEPTH = 4,
   parameter int VW    = 16
) (
   // Clock and reset
   input  wire logic              clock_i,
   input  wire logic              rstn_i,
   // Machine side
   input  wire logic              det_i,
   input  wire logic              photo_i,
   input  wire logic              tacho_i,
   output logic                   relay_o,
   output rtc_pkg::rtc_stat_s     stat_o,
   // AXI4-Lite slave
   input  wire logic              awvalid_i,
   output logic                   awready_o,
   input  wire logic [7:0]        awaddr_i,
   input  wire logic              wvalid_i,
   output logic                   wready_o,
   input  wire logic [31:0]       wdata_i,
   input  wire logic [3:0]        wstrb_i,
   output logic                   bvalid_o,
   input  wire logic              bready_i,
   output logic [1:0]             bresp_o,
   input  wire logic              arvalid_i,
   output logic                   arready_o,
   input  wire logic [7:0]        araddr_i,
   output logic                   rvalid_o,
   input  wire logic              rready_i,
   output logic [31:0]            rdata_o,
   output logic [1:0]             rresp_o
);
   import rtc_pkg::*;

   localparam int PW = (NPROD > 1) ? $clog2(NPROD) : 1;
   rtc_cfg_s          cfg_q;
   logic [PW-1:0]     act_q;
   logic [VW-1:0]     prm_q [NPROD][4];
   logic [11:0]       pre_q;
   logic [2:0]        ph_q;
   logic [2:0]        tc_q;
   logic              flag_q, ovf_q, tick, det_q, pc_edge, tc_edge, trig, dstep;
   logic [VW-1:0]     a_dly, a_rej, a_pdl, a_alm;
   logic              busy_q [2][DEPTH];
   logic [VW-1:0]     cnt_q [2][DEPTH];
   logic [DEPTH-1:0]  busy_v [2];
   logic [DEPTH-1:0]  grant [2];
   logic [DEPTH-1:0]  done [2];
   logic              push [2];
   logic              zero [2];
   logic              qexp [2];
   logic [VW-1:0]     ld [2];
   logic              qovf, win_open, fire, relay_q;
   logic [VW-1:0]     win_q, rej_d, rej_q;
   // Time base for non-distance counting
   assign tick = (pre_q == 12'(`RTC_TICK_CYC - 1));

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pre_q <= '0;
      end else begin
         pre_q <= tick ? '0 : pre_q + 12'h001;
      end
   end

   // First stage feeds only the second stage
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ph_q  <= '0;
         tc_q  <= '0;
         det_q <= 1'b0;
      end else begin
         ph_q  <= {ph_q[1:0], photo_i};
         tc_q  <= {tc_q[1:0], tacho_i};
         det_q <= det_i;
      end
   end

   assign pc_edge = cfg_q.photo_en & (ph_q[1] ^ cfg_q.photo_pol)
                    & ~(ph_q[2] ^ cfg_q.photo_pol);
   assign tc_edge = cfg_q.tacho_en & (tc_q[1] ^ cfg_q.tacho_pol)
                    & ~(tc_q[2] ^ cfg_q.tacho_pol);
   assign trig    = det_i & ~det_q;
   assign dstep   = cfg_q.tacho_en ? tc_edge : tick;

   assign a_dly = prm_q[act_q][PRM_DELAY];
   assign a_rej = prm_q[act_q][PRM_REJECT];
   assign a_pdl = prm_q[act_q][PRM_PDELAY];
   assign a_alm = prm_q[act_q][PRM_ALARM];

   function automatic logic [DEPTH-1:0] lowest(input logic [DEPTH-1:0] v);
      logic [DEPTH-1:0] r;
      r = '0;
      for (int k = DEPTH - 1; k >= 0; k--) begin
         if (v[k]) begin
            r    = '0;
            r[k] = 1'b1;
         end
      end
      return r;
   endfunction : lowest

   // Queue 0 holds trigger delays, queue 1 photocell delays
   always_comb begin
      push[0] = trig;
      push[1] = pc_edge;
      ld[0]   = a_dly;
      ld[1]   = a_pdl;
      qovf    = 1'b0;
      for (int q = 0; q < 2; q++) begin
         for (int i = 0; i < DEPTH; i++) begin
            busy_v[q][i] = busy_q[q][i];
         end
         zero[q]  = push[q] & (ld[q] == '0);
         grant[q] = (push[q] & ~zero[q]) ? lowest(~busy_v[q]) : '0;
         qovf     = qovf | (push[q] & ~zero[q] & (&busy_v[q]));
         qexp[q]  = zero[q] | (|done[q]);
      end
   end

   for (genvar q = 0; q < 2; q++) begin : g_q
      for (genvar i = 0; i < DEPTH; i++) begin : g_slot
         assign done[q][i] = busy_q[q][i] & dstep & (cnt_q[q][i] == VW'(1));
         always_ff @(posedge clock_i or negedge rstn_i) begin
            if (!rstn_i) begin
               busy_q[q][i] <= 1'b0;
               cnt_q[q][i]  <= '0;
            end else if (grant[q][i]) begin
               busy_q[q][i] <= 1'b1;
               cnt_q[q][i]  <= ld[q];
            end else if (done[q][i]) begin
               busy_q[q][i] <= 1'b0;
            end else if (busy_q[q][i] && dstep) begin
               cnt_q[q][i]  <= cnt_q[q][i] - VW'(1);
            end
         end
      end
   end

   // Alarm window; a restart while open extends it
   assign win_open = (win_q != '0);

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         win_q <= '0;
      end else if (qexp[0] && cfg_q.photo_en) begin
         win_q <= a_alm;
      end else if (!cfg_q.photo_en) begin
         win_q <= '0;
      end else if (win_open && dstep) begin
         win_q <= win_q - VW'(1);
      end
   end

   assign fire = cfg_q.photo_en ? (qexp[1] & win_open) : qexp[0];

   // Reject duration always counts time, never tacho pulses
   always_comb begin
      rej_d = rej_q;
      if (fire) begin
         rej_d = a_rej;
      end else if (rej_q != '0 && tick) begin
         rej_d = rej_q - VW'(1);
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rej_q   <= '0;
         relay_q <= 1'b0;
      end else begin
         rej_q   <= rej_d;
         relay_q <= (rej_d != '0);
      end
   end

   assign relay_o = relay_q;
   assign stat_o  = '{window: win_open, ovf: ovf_q, flag: flag_q, relay: relay_q};

   // Register access
   logic        aw_q, w_q, bv_q, rv_q, wr_go, wr_stat;
   logic [7:0]  awa_q;
   logic [31:0] wd_q;
   logic [3:0]  ws_q;
   logic [1:0]  br_q;
   logic [31:0] rd_q;
   logic [1:0]  rr_q;
   logic [32:0] wr_old;
   logic [32:0] rd_res;
   logic [31:0] wm;
   logic [7:0]  poff;

   function automatic logic [32:0] reg_rd(input logic [7:0] a);
      logic [32:0] r;
      logic [7:0]  o;
      r = {1'b1, 32'h0000_0000};
      o = a - `RTC_PRM_BASE;
      if (a == `RTC_CTRL_OFS) begin
         r[3:0] = cfg_q;
      end else if (a == `RTC_PSEL_OFS) begin
         r[PW-1:0] = act_q;
      end else if (a == `RTC_NEW_OFS) begin
         r[PW-1:0] = act_q;
      end else if (a == `RTC_STAT_OFS) begin
         r[3:0] = {win_open, ovf_q, flag_q, relay_q};
      end else if (a >= `RTC_PRM_BASE && 32'(o) < 32'(NPROD * 16) && a[1:0] == 2'b00) begin
         r[VW-1:0] = prm_q[o[PW+3:4]][o[3:2]];
      end else begin
         r[32] = 1'b0;
      end
      return r;
   endfunction : reg_rd

   assign awready_o = ~aw_q & ~bv_q;
   assign wready_o  = ~w_q & ~bv_q;
   assign arready_o = ~rv_q;
   assign bvalid_o  = bv_q;
   assign bresp_o   = br_q;
   assign rvalid_o  = rv_q;
   assign rdata_o   = rd_q;
   assign rresp_o   = rr_q;
   assign wr_go     = aw_q & w_q & ~bv_q;
   assign wr_old    = reg_rd(awa_q);
   assign rd_res    = reg_rd(araddr_i);
   assign poff      = awa_q - `RTC_PRM_BASE;
   assign wr_stat   = wr_go & (awa_q == `RTC_STAT_OFS);

   // Byte strobes merge the write into the current value
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         wm[b*8 +: 8] = ws_q[b] ? wd_q[b*8 +: 8] : wr_old[b*8 +: 8];
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         aw_q  <= 1'b0;
         w_q   <= 1'b0;
         awa_q <= '0;
         wd_q  <= '0;
         ws_q  <= '0;
         bv_q  <= 1'b0;
         br_q  <= `RTC_OKAY;
      end else begin
         if (awvalid_i && awready_o) begin
            aw_q  <= 1'b1;
            awa_q <= awaddr_i;
         end
         if (wvalid_i && wready_o) begin
            w_q  <= 1'b1;
            wd_q <= wdata_i;
            ws_q <= wstrb_i;
         end
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
            bv_q <= 1'b1;
            br_q <= wr_old[32] ? `RTC_OKAY : `RTC_SLVERR;
         end else if (bv_q && bready_i) begin
            bv_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rv_q <= 1'b0;
         rd_q <= '0;
         rr_q <= `RTC_OKAY;
      end else if (arvalid_i && arready_o) begin
         rv_q <= 1'b1;
         rd_q <= rd_res[31:0];
         rr_q <= rd_res[32] ? `RTC_OKAY : `RTC_SLVERR;
      end else if (rv_q && rready_i) begin
         rv_q <= 1'b0;
      end
   end

   // Configuration, product select and timer sets
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cfg_q <= `RTC_CTRL_RST;
         act_q <= '0;
         for (int p = 0; p < NPROD; p++) begin
            for (int k = 0; k < 4; k++) begin
               prm_q[p][k] <= (k == 1) ? `RTC_REJ_RST : `RTC_PRM_RST;
            end
         end
      end else if (wr_go && wr_old[32]) begin
         if (awa_q == `RTC_CTRL_OFS) begin
            cfg_q <= wm[3:0];
         end else if (awa_q == `RTC_PSEL_OFS) begin
            act_q <= wm[PW-1:0];
         end else if (awa_q == `RTC_NEW_OFS) begin
            prm_q[wm[PW-1:0]] <= prm_q[act_q];
            act_q             <= wm[PW-1:0];
         end else if (awa_q >= `RTC_PRM_BASE) begin
            prm_q[poff[PW+3:4]][poff[3:2]] <= wm[VW-1:0];
         end
      end
   end

   // Sticky flags: a new event wins over a same-cycle clear
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         flag_q <= 1'b0;
         ovf_q  <= 1'b0;
      end else begin
         flag_q <= fire | (flag_q & ~(wr_stat & wm[`RTC_ST_FLAG]));
         ovf_q  <= qovf | (ovf_q & ~(wr_stat & wm[`RTC_ST_OVF]));
      end
   end

   a_zero_delay: assert property (@(posedge clock_i) disable iff (!rstn_i)
      trig && a_dly == '0 && !cfg_q.photo_en && a_rej != '0 |=> relay_o)
      else $error("Zero delay did not fire at once");
   a_direct_fire: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !cfg_q.photo_en && qexp[0] |=> rej_q == $past(a_rej))
      else $error("Delay expiry did not load reject time");
   a_relay_len: assert property (@(posedge clock_i) disable iff (!rstn_i)
      rej_q == VW'(1) && tick && !fire |=> !relay_o)
      else $error("Relay did not release at end of reject");
   a_window_gate: assert property (@(posedge clock_i) disable iff (!rstn_i)
      cfg_q.photo_en && fire |-> win_open && qexp[1])
      else $error("Reject outside alarm window");
   a_window_open: assert property (@(posedge clock_i) disable iff (!rstn_i)
      cfg_q.photo_en && qexp[0] && a_alm != '0 |=> win_open && win_q == $past(a_alm))
      else $error("Alarm window did not start");
   a_flag_set: assert property (@(posedge clock_i) disable iff (!rstn_i)
      fire |=> flag_q ##1 (flag_q || $past(wr_stat)))
      else $error("Reject flag not raised");
   a_ovf_report: assert property (@(posedge clock_i) disable iff (!rstn_i)
      trig && a_dly != '0 && (&busy_v[0]) |=> ovf_q)
      else $error("Queue overflow not reported");
   a_dist_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
      cfg_q.tacho_en && !tc_edge && busy_q[0][0] && !grant[0][0] |=> $stable(cnt_q[0][0]))
      else $error("Delay moved without tacho pulse");
   a_no_photo: assert property (@(posedge clock_i) disable iff (!rstn_i)
      !cfg_q.photo_en |-> !pc_edge && !grant[1][0])
      else $error("Photocell active while disabled");
endmodule : rtc_top
`default_nettype wire

/* File: dv/rtc_partner.sv */
// Machine-side model: photocell and tacho sensors with configurable polarity
`timescale 1ns/1ps
`default_nettype none
module rtc_partner (
   // Sensor activity from the bench
   input  wire logic photo_act_i,
   input  wire logic tacho_act_i,
   input  wire logic photo_pol_i,
   input  wire logic tacho_pol_i,
   // Pins toward the block
   output logic      photo_o,
   output logic      tacho_o
);
   // Pin level is the active level turned by the wiring polarity
   assign photo_o = photo_act_i ^ photo_pol_i;
   assign tacho_o = tacho_act_i ^ tacho_pol_i;
endmodule : rtc_partner
`default_nettype wire

/* File: dv/tb_top.sv */
// Self-checking bench for the reject timing controller
`timescale 1ns/1ps
`default_nettype none
`include "rtc_consts.svh"
module tb_top;
   import rtc_pkg::*;
   localparam int T = `RTC_TICK_CYC;
   logic        clock_i, rstn_i, det, ph_act, ta_act, ph_pol, ta_pol, photo, tacho, relay;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, det_p, rel_p;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, rd;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, rs;
   rtc_stat_s   stat;
   int          n_mismatch, check_count, cyc, rs_c, ap, p, prm[16];
   int          trig_q[$], rise_q[$], len_q[$];

   rtc_top dut_u (.clock_i(clock_i), .rstn_i(rstn_i), .det_i(det), .photo_i(photo),
      .tacho_i(tacho), .relay_o(relay), .stat_o(stat), .awvalid_i(awvalid),
      .awready_o(awready), .awaddr_i(awaddr), .wvalid_i(wvalid), .wready_o(wready),
      .wdata_i(wdata), .wstrb_i(wstrb), .bvalid_o(bvalid), .bready_i(bready),
      .bresp_o(bresp), .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr),
      .rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp));
   rtc_partner prt_u (.photo_act_i(ph_act), .tacho_act_i(ta_act), .photo_pol_i(ph_pol),
      .tacho_pol_i(ta_pol), .photo_o(photo), .tacho_o(tacho));

   initial begin
      clock_i = 1'b0;
      forever #2 clock_i = ~clock_i;
   end

   // Edge log of trigger and relay; also cuts a hang short
   always @(posedge clock_i) begin
      cyc++;
      if (det === 1'b1 && !det_p) trig_q.push_back(cyc);
      if (relay === 1'b1 && !rel_p) begin
         rise_q.push_back(cyc);
         rs_c = cyc;
      end
      if (relay === 1'b0 && rel_p) len_q.push_back(cyc - rs_c);
      det_p = (det === 1'b1);
      rel_p = (relay === 1'b1);
      if (cyc > 90000) begin
         n_mismatch++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_in(input int v, input int lo, input int hi);
      check_count++;
      if (v < lo || v > hi) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
      end
   endtask : chk_in

   task automatic wt(input int n);
      repeat (n) @(posedge clock_i);
   endtask : wt

   // Bus cycles; each channel released on its own handshake
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      awaddr  <= a;
      wdata   <= d;
      do begin
         @(posedge clock_i);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
   endtask : axw

   task automatic axr(input logic [7:0] a);
      arvalid <= 1'b1;
      araddr  <= a;
      do begin
         @(posedge clock_i);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
   endtask : axr

   task automatic setp(input int k, input int v);
      axw(8'(64 + ap * 16 + k * 4), 32'(v));
      prm[ap * 4 + k] = v;
   endtask : setp

   task automatic chk_prm();
      for (int i = 0; i < 16; i++) begin
         axr(8'(64 + i * 4));
         chk(rd, 32'(prm[i]));
      end
   endtask : chk_prm

   task automatic trig();
      det <= 1'b1;
      wt(1);
      det <= 1'b0;
      wt(1);
   endtask : trig

   task automatic sens(input bit t);
      if (t) ta_act <= 1'b1;
      else ph_act <= 1'b1;
      wt(4);
      ta_act <= 1'b0;
      ph_act <= 1'b0;
      wt(4);
   endtask : sens

   task automatic clr();
      trig_q.delete();
      rise_q.delete();
      len_q.delete();
   endtask : clr

   task automatic done(input string s);
      $display("%s done, mismatches %0d", s, n_mismatch);
   endtask : done

   initial begin
      rstn_i = 1'b0;
      det = 1'b0;
      ph_act = 1'b0;
      ta_act = 1'b0;
      ph_pol = 1'b0;
      ta_pol = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      arvalid = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hf;
      bready = 1'b1;
      rready = 1'b1;
      n_mismatch = 0;
      check_count = 0;
      cyc = 0;
      ap = 0;
      det_p = 1'b0;
      rel_p = 1'b0;
      for (int i = 0; i < 16; i++) prm[i] = (i % 4 == 1) ? `RTC_REJ_RST : 0;
      void'($urandom(32'h459b5990));
      wt(4);
      rstn_i <= 1'b1;
      wt(1);
      axr(`RTC_CTRL_OFS);
      chk(rd, `RTC_CTRL_RST);
      chk_prm();
      axr(8'h20);
      chk({30'h0, rs}, `RTC_SLVERR);
      chk(rd, 32'h0);
      axr(8'h41);
      chk({30'h0, rs}, `RTC_SLVERR);
      axw(8'h20, 32'h1);
      chk({30'h0, rs}, `RTC_SLVERR);
      done("reset");
      // Random set on product 0, then a new product copies it
      for (int k = 0; k < 4; k++) setp(k, int'($urandom & 32'hffff));
      axw(`RTC_NEW_OFS, 32'h2);
      ap = 2;
      for (int k = 0; k < 4; k++) prm[8 + k] = prm[k];
      axr(`RTC_PSEL_OFS);
      chk(rd, 32'h2);
      chk_prm();
      axw(`RTC_PSEL_OFS, 32'h1);
      axr(`RTC_PSEL_OFS);
      chk(rd, 32'h1);
      axw(`RTC_PSEL_OFS, 32'h2);
      done("new product");
      // Zero delay; random photocell values must not matter here
      setp(0, 0);
      setp(1, 2);
      clr();
      trig();
      wt(2 * T + 10);
      chk_in(rise_q[0] - trig_q[0], 1, 1);
      chk_in(len_q[0], T, 2 * T + 1);
      axr(`RTC_STAT_OFS);
      chk(rd, 32'h2);
      chk(32'(stat), 32'h2);
      axw(`RTC_STAT_OFS, 32'h2);
      axr(`RTC_STAT_OFS);
      chk(rd, 32'h0);
      done("zero delay");
      // Two triggers, each rejected after its own full delay
      setp(0, 2);
      clr();
      trig();
      wt(4 * T);
      trig();
      wt(4 * T + 10);
      chk(rise_q.size(), 2);
      for (int i = 0; i < 2; i++) chk_in(rise_q[i] - trig_q[i], T + 2, 2 * T + 3);
      done("delay");
      // Slots run out on a burst; two ticks so no slot frees mid-burst
      setp(0, 2);
      clr();
      repeat (5) trig();
      axr(`RTC_STAT_OFS);
      chk(rd & 32'h4, 32'h4);
      wt(3 * T);
      chk(rise_q.size(), 1);
      axw(`RTC_STAT_OFS, 32'h6);
      done("overflow");
      // Photocell mode, inverted photocell wiring
      ph_pol <= 1'b1;
      axw(`RTC_CTRL_OFS, 32'h3);
      setp(0, 1);
      setp(2, 1);
      setp(3, 3);
      clr();
      sens(0);
      wt(2 * T);
      chk(rise_q.size(), 0);
      trig();
      wt(T + 10);
      axr(`RTC_STAT_OFS);
      chk(rd & 32'h8, 32'h8);
      p = cyc;
      sens(0);
      wt(T + 10);
      chk(rise_q.size(), 1);
      chk_in(rise_q[0] - p, 2, T + 8);
      wt(3 * T);
      axr(`RTC_STAT_OFS);
      chk(rd & 32'h8, 32'h0);
      sens(0);
      wt(2 * T);
      chk(rise_q.size(), 1);
      done("photocell");
      // Variable speed, inverted tacho wiring; reject still in time
      ta_pol <= 1'b1;
      axw(`RTC_CTRL_OFS, 32'hc);
      setp(0, 3);
      clr();
      trig();
      wt(4 * T);
      chk(rise_q.size(), 0);
      sens(1);
      sens(1);
      wt(20);
      chk(rise_q.size(), 0);
      sens(1);
      wt(20);
      chk(rise_q.size(), 1);
      wt(2 * T + 10);
      chk_in(len_q[0], T, 2 * T + 1);
      done("tacho");
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
